// >>> phy_event_pkg.sv
// Purpose: Constants and carrier types for the PHY event status block
// Assumes: AXI4-Lite register access, word per register, index * 4 = byte
// Notes: Status bits sit in 15:8 and their enables in 7:0 of each bank
package phy_event_pkg;
   // Register indices; byte address is index times four
   localparam logic [5:0] IDX_INT_CTRL = 6'h11;
   localparam logic [5:0] IDX_BANK1 = 6'h12;
   localparam logic [5:0] IDX_BANK2 = 6'h13;
   localparam logic [5:0] IDX_FALSE_CARRIER = 6'h14;
   localparam logic [5:0] IDX_RX_ERROR = 6'h15;
   localparam int ADDR_WIDTH = 8;
   localparam int STATUS_LSB = 8;
   localparam int BANK_BITS = 8;
   localparam int GLOBAL_EN_BIT = 1;
   // Bank1 status positions of the counter half-full flags (bits 9, 8)
   localparam int B1_FC_HALF_BIT = 1;
   localparam int B1_RE_HALF_BIT = 0;
   localparam logic [7:0] FC_MAX = 8'hff;
   localparam logic [7:0] HALF_FULL = 8'h7f;
   localparam logic [15:0] RE_MAX_DEFAULT = 16'h00ff;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   // Event strobes from the neighbouring detectors, one cycle each; rx_dv and mii_loopback are level qualifiers
   typedef struct packed {
      logic link_quality;
      logic energy_change;
      logic link_change;
      logic speed_change;
      logic duplex_change;
      logic an_complete;
      logic eee_error;
      logic an_error;
      logic page_received;
      logic loop_fifo_error;
      logic mdix_change;
      logic sleep_event;
      logic polarity_change;
      logic wol_packet;
      logic jabber;
      logic false_carrier;
      logic rx_symbol_error;
      logic rx_dv;
      logic mii_loopback;
   } phy_events_type;
endpackage : phy_event_pkg

// >>> phy_event_status.sv
// Purpose: Event status banks, enables, error counters, AXI4-Lite slave
// Assumes: Event inputs synchronous to aclk, one pulse per event
// Notes: Reading a status bank or counter clears it in the same handshake
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/100ps
module phy_event_status
   import phy_event_pkg::*;
#(
   parameter int RE_WIDTH = 16,
   parameter logic [15:0] RE_MAX = RE_MAX_DEFAULT
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire phy_events_type events,
   input wire logic [ADDR_WIDTH-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_WIDTH-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic irq
);

   // Refuse shapes the counter logic cannot hold
   if (RE_WIDTH != 16 || RE_MAX <= 16'(HALF_FULL)) begin : g_bad_params
      $error("phy_event_status: bad receive counter parameters");
   end

   logic [BANK_BITS-1:0] bank1_stat;
   logic [BANK_BITS-1:0] bank1_en;
   logic [BANK_BITS-1:0] bank2_stat;
   logic [BANK_BITS-1:0] bank2_en;
   logic [BANK_BITS-1:0] bank1_cause;
   logic [BANK_BITS-1:0] bank2_cause;
   logic global_en;
   logic [7:0] fc_count;
   logic [RE_WIDTH-1:0] re_count;
   logic fc_inc;
   logic re_inc;
   logic fc_half;
   logic re_half;
   logic fc_clr;
   logic re_clr;
   logic bank1_clr;
   logic bank2_clr;
   logic rd_fire;
   logic [5:0] rd_idx;
   logic aw_full;
   logic w_full;
   logic [5:0] wr_idx;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_do;
   logic [31:0] next_rdata;
   logic next_rmiss;

   // Read handshake decode; clears act on the word being returned
   assign rd_fire = arvalid && arready;
   assign rd_idx = araddr[7:2];
   assign fc_clr = rd_fire && rd_idx == IDX_FALSE_CARRIER;
   assign re_clr = rd_fire && rd_idx == IDX_RX_ERROR;
   assign bank1_clr = rd_fire && rd_idx == IDX_BANK1;
   assign bank2_clr = rd_fire && rd_idx == IDX_BANK2;

   // Counter increment qualifiers
   assign fc_inc = events.false_carrier && fc_count != FC_MAX;
   assign re_inc = events.rx_symbol_error && events.rx_dv
      && !events.mii_loopback
      && re_count != RE_MAX;

   // Half-full fires on the step from 7Fh to 80h; a clear that same
   // cycle restarts the count so no crossing happens
   assign fc_half = fc_inc && !fc_clr && fc_count == HALF_FULL;
   assign re_half = re_inc && !re_clr
      && re_count == 16'(HALF_FULL);

   // Bank2 causes, one per status bit
   assign bank2_cause[7] = events.eee_error;
   assign bank2_cause[6] = events.an_error;
   assign bank2_cause[5] = events.page_received;
   assign bank2_cause[4] = events.loop_fifo_error;
   assign bank2_cause[3] = events.mdix_change;
   assign bank2_cause[2] = events.sleep_event;
   // Polarity and WoL share one flag, software cannot tell them apart
   assign bank2_cause[1] = events.polarity_change | events.wol_packet;
   assign bank2_cause[0] = events.jabber;

   // Bank1 causes; counter half-full feeds bits 9 and 8
   assign bank1_cause[7:2] = {events.link_quality, events.energy_change,
      events.link_change, events.speed_change, events.duplex_change,
      events.an_complete};
   assign bank1_cause[B1_FC_HALF_BIT] = fc_half;
   assign bank1_cause[B1_RE_HALF_BIT] = re_half;

   // Latched status per bit; the set wins over a read clear
   for (genvar i = 0; i < BANK_BITS; i++) begin : g_latch
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            bank1_stat[i] <= 1'b0;
            bank2_stat[i] <= 1'b0;
         end else begin
            bank1_stat[i] <= (bank1_stat[i] && !bank1_clr)
               || bank1_cause[i];
            bank2_stat[i] <= (bank2_stat[i] && !bank2_clr)
               || bank2_cause[i];
         end
      end
   end

   // False carrier counter; an event during the clearing read counts 1
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fc_count <= 8'h00;
      end else if (fc_clr) begin
         fc_count <= {7'h00, events.false_carrier};
      end else if (fc_inc) begin
         fc_count <= fc_count + 8'h01;
      end
   end

   // Receive error counter, same clear-on-read treatment
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         re_count <= '0;
      end else if (re_clr) begin
         re_count <= RE_WIDTH'(events.rx_symbol_error && events.rx_dv
            && !events.mii_loopback);
      end else if (re_inc) begin
         re_count <= re_count + RE_WIDTH'(1);
      end
   end

   // Write channel capture; address and data may arrive in any order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
         wr_idx <= 6'h00;
         wr_data <= RESET_WORD;
         wr_strb <= 4'h0;
      end else if (bvalid && bready) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
      end else begin
         if (awvalid && awready) begin
            aw_full <= 1'b1;
            awready <= 1'b0;
            wr_idx <= awaddr[7:2];
         end
         if (wvalid && wready) begin
            w_full <= 1'b1;
            wready <= 1'b0;
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
      end
   end

   assign wr_do = aw_full && w_full && !bvalid;

   // Write response, one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (wr_do) begin
         bvalid <= 1'b1;
         if (wr_idx == IDX_INT_CTRL || wr_idx == IDX_BANK1
               || wr_idx == IDX_BANK2 || wr_idx == IDX_FALSE_CARRIER
               || wr_idx == IDX_RX_ERROR) begin
            bresp <= RESP_OKAY;
         end else begin
            bresp <= RESP_SLVERR;
         end
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Enable and control writes; status and counters ignore writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bank1_en <= '0;
         bank2_en <= '0;
         global_en <= 1'b0;
      end else if (wr_do && wr_strb[0]) begin
         if (wr_idx == IDX_BANK1) begin
            bank1_en <= wr_data[BANK_BITS-1:0];
         end else if (wr_idx == IDX_BANK2) begin
            bank2_en <= wr_data[BANK_BITS-1:0];
         end else if (wr_idx == IDX_INT_CTRL) begin
            global_en <= wr_data[GLOBAL_EN_BIT];
         end
      end
   end

   // Read data mux over present values
   always_comb begin
      next_rdata = RESET_WORD;
      next_rmiss = 1'b0;
      if (rd_idx == IDX_INT_CTRL) begin
         next_rdata[GLOBAL_EN_BIT] = global_en;
      end else if (rd_idx == IDX_BANK1) begin
         next_rdata[15:0] = {bank1_stat, bank1_en};
      end else if (rd_idx == IDX_BANK2) begin
         next_rdata[15:0] = {bank2_stat, bank2_en};
      end else if (rd_idx == IDX_FALSE_CARRIER) begin
         next_rdata[7:0] = fc_count;
      end else if (rd_idx == IDX_RX_ERROR) begin
         next_rdata[15:0] = re_count;
      end else begin
         next_rmiss = 1'b1;
      end
   end

   // Read channel; one read in flight
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= RESET_WORD;
         rresp <= RESP_OKAY;
      end else if (rd_fire) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= next_rdata;
         rresp <= next_rmiss ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // Interrupt request, registered so the pin never glitches
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= global_en
            && (|(bank1_stat & bank1_en) || |(bank2_stat & bank2_en));
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_fc_step;
      events.false_carrier && !fc_clr && fc_count != FC_MAX;
   endsequence
   sequence s_pending;
      global_en && (|(bank1_stat & bank1_en) || |(bank2_stat & bank2_en));
   endsequence
   sequence s_write_held;
      aw_full && w_full && !bvalid;
   endsequence

   a_eee_error_latch: assert property (
      events.eee_error |=> bank2_stat[7])
      else $error("EEE error flag not latched");
   a_wol_shared_flag: assert property (
      events.wol_packet |=> bank2_stat[1])
      else $error("WoL packet did not set shared flag");
   a_status_set_wins: assert property (
      bank2_clr && events.jabber |=> bank2_stat[0])
      else $error("event lost during clearing read");
   a_fc_count_step: assert property (
      s_fc_step |=> fc_count == $past(fc_count) + 8'h01)
      else $error("false carrier count did not step");
   a_fc_saturate: assert property (
      fc_count == FC_MAX && !fc_clr |=> fc_count == FC_MAX)
      else $error("false carrier count wrapped");
   a_fc_read_clear: assert property (
      fc_clr && !events.false_carrier |=> fc_count == 8'h00)
      else $error("false carrier count not cleared by read");
   a_re_loopback_hold: assert property (
      (events.mii_loopback || !events.rx_dv) && !re_clr |=> $stable(re_count))
      else $error("receive errors counted while blocked");
   a_re_saturate: assert property (
      re_count == RE_MAX && !re_clr |=> re_count == RE_MAX)
      else $error("receive error count passed its maximum");
   a_re_half_flag: assert property (
      re_count == 16'(HALF_FULL) && re_inc && !re_clr
      |=> re_count == 16'(HALF_FULL) + 16'h0001 && bank1_stat[B1_RE_HALF_BIT])
      else $error("receive error half-full flag missing");
   a_irq_needs_global: assert property (
      !global_en |=> !irq)
      else $error("interrupt without global enable");
   a_irq_from_pending: assert property (
      s_pending |=> irq)
      else $error("enabled pending event gave no interrupt");
   a_write_answer: assert property (
      s_write_held |=> bvalid ##1 (bvalid || !aw_full))
      else $error("write response missing");
   a_an_error_latch: assert property (
      events.an_error |=> bank2_stat[6])
      else $error("auto-negotiation error flag not latched");
   a_page_rx_latch: assert property (
      events.page_received |=> bank2_stat[5])
      else $error("page received flag not latched");
   a_fifo_err_latch: assert property (
      events.loop_fifo_error |=> bank2_stat[4])
      else $error("loopback FIFO flag not latched");
   a_mdix_latch: assert property (
      events.mdix_change |=> bank2_stat[3])
      else $error("crossover change flag not latched");
   a_sleep_latch: assert property (
      events.sleep_event |=> bank2_stat[2])
      else $error("sleep event flag not latched");
   a_polarity_latch: assert property (
      events.polarity_change |=> bank2_stat[1])
      else $error("polarity flag not latched");
   a_jabber_latch: assert property (
      events.jabber |=> bank2_stat[0])
      else $error("jabber flag not latched");
   a_enable_hold: assert property (
      !(wr_do && wr_strb[0]) |=> $stable(bank2_en) && $stable(bank1_en))
      else $error("enables changed without a write");
   a_fc_half_flag: assert property (
      fc_count == HALF_FULL && fc_inc && !fc_clr
      |=> bank1_stat[B1_FC_HALF_BIT])
      else $error("false carrier half-full flag missing");
   a_re_count_step: assert property (
      re_inc && !re_clr |=> re_count == $past(re_count) + 16'h0001)
      else $error("receive error count did not step");
   a_re_read_clear: assert property (
      re_clr && !events.rx_symbol_error |=> re_count == '0)
      else $error("receive error count not cleared by read");
   a_status_hold: assert property (
      bank2_stat[0] && !bank2_clr |=> bank2_stat[0])
      else $error("status bit dropped without a read");

endmodule : phy_event_status

// >>> phy_host_model.sv
// Purpose: Management host model, AXI4-Lite master for the event block
// Assumes: One write and one read at a time, signals moved after posedge
// Notes: Released payload shows inverted data so stale values never match
`timescale 1ns/100ps
module phy_host_model
   import phy_event_pkg::*;
(
   input wire logic aclk,
   output logic [ADDR_WIDTH-1:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [ADDR_WIDTH-1:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   // Idle bus at time zero
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [ADDR_WIDTH-1:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (awvalid && awready && !aw_done) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (wvalid && wready && !w_done) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
            wdata <= ~d;
         end
      end
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   // Read with rready held until the answer is sampled
   task automatic rd(input logic [ADDR_WIDTH-1:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      araddr <= ~a;
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
endmodule : phy_host_model

// >>> tb.sv
// Purpose: Self-checking bench for the PHY event status block
// Assumes: Default receive error ceiling, host model as bus master
// Notes: Events drive as one-cycle strobes, counters by held strobes
`timescale 1ns/100ps
module tb
   import phy_event_pkg::*;
;
   localparam logic [7:0] A_CTRL = {IDX_INT_CTRL, 2'b00};
   localparam logic [7:0] A_B1 = {IDX_BANK1, 2'b00};
   localparam logic [7:0] A_B2 = {IDX_BANK2, 2'b00};
   localparam logic [7:0] A_FC = {IDX_FALSE_CARRIER, 2'b00};
   localparam logic [7:0] A_RE = {IDX_RX_ERROR, 2'b00};
   logic aclk, aresetn, irq;
   phy_events_type ev;
   logic [7:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [7:0] e;
   int num_errors, checks, n;

   phy_event_status dut (.aclk(aclk), .aresetn(aresetn), .events(ev),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .irq(irq));
   phy_host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready));

   // 250 MHz clock
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   task automatic chk(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic end_sim;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim

   // Read a register and compare the word and an OKAY answer
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                      input string name);
      host.rd(a, d, r);
      chk(name, d, exp);
      chk("rresp", {30'h0, r}, {30'h0, RESP_OKAY});
   endtask : rdc

   // Strobe held high for n edges gives n events
   task automatic hold(input logic [18:0] mask, input int cnt);
      @(posedge aclk);
      ev <= phy_events_type'(ev | mask);
      repeat (cnt) @(posedge aclk);
      ev <= phy_events_type'(ev & ~mask);
   endtask : hold

   // Expected count: receive errors gated and capped, false carrier capped
   function automatic logic [31:0] exp_cnt(int cnt, bit re, bit dv, bit lb);
      if (re)
         return (!dv || lb) ? 32'h0 : (cnt > RE_MAX_DEFAULT ?
                {16'h0, RE_MAX_DEFAULT} : 32'(cnt));
      return cnt > 255 ? 32'h0000_00ff : 32'(cnt);
   endfunction : exp_cnt

   // One counter run, then count, half-full flag and clear checked
   task automatic cnt_run(input bit re, input int cnt, input bit dv,
                          input bit lb);
      logic [31:0] x;
      x = exp_cnt(cnt, re, dv, lb);
      @(posedge aclk);
      ev.rx_dv <= dv;
      ev.mii_loopback <= lb;
      hold(re ? 19'h00004 : 19'h00008, cnt);
      rdc(re ? A_RE : A_FC, x, "count");
      rdc(re ? A_RE : A_FC, 32'h0, "count cleared");
      rdc(A_B1, (x >= 32'h80) ? (re ? 32'h100 : 32'h200) : 32'h0,
          "half full");
   endtask : cnt_run

   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      end_sim();
   end

   initial begin
      num_errors = 0;
      checks = 0;
      ev = '0;
      aresetn = 1'b0;
      n = $urandom(32'hd5148bcf);
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // Reset values and an unmapped place
      rdc(A_B2, 32'h0, "bank2 reset");
      rdc(A_FC, 32'h0, "fc reset");
      rdc(A_RE, 32'h0, "re reset");
      host.rd(8'h00, d, r);
      chk("unmapped rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
      chk("unmapped rdata", d, 32'h0);
      host.wr(8'h00, 32'h1, r);
      chk("unmapped bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
      // Enables read back, status bits not writable
      e = 8'($urandom);
      host.wr(A_B2, {24'hffffff, e}, r);
      rdc(A_B2, {24'h0, e}, "bank2 enables");
      // Each bank2 event latches its bit (polarity and WoL share bit 1), read clears
      for (int i = 0; i < 9; i++) begin
         hold(19'h01000 >> i, 1);
         repeat (3) @(posedge aclk);
         rdc(A_B2, {16'h0, 8'h80 >> (i < 7 ? i : i - 1), e},
             "bank2 event");
         rdc(A_B2, {24'h0, e}, "bank2 cleared");
         chk("irq no global", {31'h0, irq}, 32'h0);
      end
      // Event in the very cycle of the clearing read survives
      fork
         rdc(A_B2, {24'h0, e}, "coincident read");
         hold(19'h00010, 1);
      join
      rdc(A_B2, {24'h0, e} | 32'h100, "coincident kept");
      // Interrupt needs status, its enable and the global enable
      host.wr(A_B2, 32'h01, r);
      hold(19'h00040, 1);
      repeat (3) @(posedge aclk);
      chk("irq masked", {31'h0, irq}, 32'h0);
      host.wr(A_CTRL, 32'h02, r);
      repeat (2) @(posedge aclk);
      chk("irq disabled bit", {31'h0, irq}, 32'h0);
      hold(19'h00010, 1);
      repeat (3) @(posedge aclk);
      chk("irq raised", {31'h0, irq}, 32'h1);
      rdc(A_B2, 32'h301, "bank2 pending");
      repeat (2) @(posedge aclk);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      // Bank1 event reaches irq through its own enable bit
      host.wr(A_B1, 32'h04, r);
      chk("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
      rdc(A_CTRL, 32'h2, "global enable");
      hold(19'h02000, 1);
      repeat (3) @(posedge aclk);
      chk("irq bank1", {31'h0, irq}, 32'h1);
      // Mid-run reset drops enables, status, global enable and irq
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("after reset", {26'h0, awready, wready, arready, bvalid, rvalid,
          irq}, 32'h38);
      rdc(A_B1, 32'h0, "bank1 reset");
      rdc(A_CTRL, 32'h0, "ctrl reset");
      // Counters: half-full boundary, saturation past the ceiling, then random
      cnt_run(1'b0, 127, 1'b0, 1'b0);
      cnt_run(1'b0, 128, 1'b0, 1'b0);
      cnt_run(1'b0, 300, 1'b0, 1'b0);
      cnt_run(1'b1, 128, 1'b1, 1'b0);
      cnt_run(1'b1, 300, 1'b1, 1'b0);
      cnt_run(1'b1, 50, 1'b0, 1'b0);
      cnt_run(1'b1, 50, 1'b1, 1'b1);
      repeat (6) begin
         n = $urandom_range(1, 280);
         cnt_run(1'($urandom), n, 1'($urandom), 1'($urandom));
      end
      end_sim();
   end
endmodule : tb
